// [design/pcrs_pkg.sv]
// constants for the program counter and return stack block
package pcrs_pkg;
  localparam int PC_W = 15;
  localparam int DEPTH = 16;
  localparam int IDX_W = 5;
  localparam logic [4:0] IDX_EMPTY = 5'h1f;
  localparam logic [4:0] IDX_FULL = 5'h0f;
  localparam logic [14:0] PC_RESET = 15'h0000;
  // register word indexes; the bus byte address is the index times four
  localparam logic [11:0] IX_STATUS_COPY = 12'hfe4;
  localparam logic [11:0] IX_ACC_COPY = 12'hfe5;
  localparam logic [11:0] IX_BANK_COPY = 12'hfe6;
  localparam logic [11:0] IX_LATCH_COPY = 12'hfe7;
  localparam logic [11:0] IX_PTR0L_COPY = 12'hfe8;
  localparam logic [11:0] IX_PTR0H_COPY = 12'hfe9;
  localparam logic [11:0] IX_PTR1L_COPY = 12'hfea;
  localparam logic [11:0] IX_PTR1H_COPY = 12'hfeb;
  localparam logic [11:0] IX_STACK_INDEX = 12'hfed;
  localparam logic [11:0] IX_TOP_LOW = 12'hfee;
  localparam logic [11:0] IX_TOP_HIGH = 12'hfef;
  localparam logic [11:0] IX_PC_LOW = 12'hf00;
  localparam logic [11:0] IX_PC_LATCH = 12'hf01;
  localparam logic [11:0] IX_FLAGS = 12'hf02;
  localparam logic [11:0] IX_PC_FULL_LO = 12'hf03;
  localparam logic [11:0] IX_PC_FULL_HI = 12'hf04;
  localparam int ADDR_W = 14;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_UNF = 1;
  localparam int FLAG_FAULT_EN = 2;
  localparam int N_COPIES = 8;
  typedef enum logic [7:0] {
    PCRS_OP_NONE = 8'h01,
    PCRS_OP_STEP = 8'h02,
    PCRS_OP_CALL = 8'h04,
    PCRS_OP_COMPUTED_SUBROUTINE_INSTR = 8'h08,
    PCRS_OP_JUMPW = 8'h10,
    PCRS_OP_JUMPREL = 8'h20,
    PCRS_OP_RETURN = 8'h40,
    PCRS_OP_VECTOR = 8'h80
  } pcrs_op_type;
endpackage

// [design/pcrs_stack_mem.sv]
// return stack storage, sixteen fifteen-bit entries
module pcrs_stack_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 15
) (
  // clock
  input wire logic sys_clk,
  // write port
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  // read port
  input wire logic [3:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] entry_reg [DEPTH];

  // contents survive reset on purpose, like the real stack
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gen_entry
      always_ff @(posedge sys_clk) begin
        if (wr_en && wr_idx == 4'(g)) begin
          entry_reg[g] <= wr_data;
        end
      end
    end
  endgenerate

  assign rd_data = entry_reg[rd_idx];
endmodule

// [design/pcrs_context_copy.sv]
// shadow register bank for context saving, untouched by reset
module pcrs_context_copy #(
  parameter int N = 8
) (
  // clock
  input wire logic sys_clk,
  // core side save
  input wire logic save,
  input wire logic [8*N-1:0] save_data,
  // software side
  input wire logic sw_wr,
  input wire logic [2:0] sw_idx,
  input wire logic [7:0] sw_data,
  output logic [8*N-1:0] copy_data
);
  logic [7:0] copy_reg [N];

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_copy
      always_ff @(posedge sys_clk) begin
        if (save) begin
          copy_reg[g] <= save_data[8*g +: 8];
        end else if (sw_wr && sw_idx == 3'(g)) begin
          copy_reg[g] <= sw_data;
        end
      end
      assign copy_data[8*g +: 8] = copy_reg[g];
    end
  endgenerate
endmodule

// [design/pcrs_core.sv]
// program counter sequencing and return stack with register slave
// Summary of operation
// - fifteen-bit counter, low byte readable, high latched
// - any reset clears program counter
// - low byte write loads upper from latch
// - call: operand bits, latch bits six..three
// - computed call: working reg plus latch
// - register jump: incremented counter plus unsigned
// - relative jump: incremented plus signed operand
// - sixteen fifteen-bit return stack entries
// - push on calls/vector, pop on returns
// - stack traffic leaves high latch alone
// - fault reset off: stack wraps circularly
// - flags set regardless of fault reset
// - index and top pair software accessible
// - index five bits, points at use
// - push increments first, pop reads first
// - empty index is 0x1f, reset value
// - context copies, unchanged by reset
// - fault reset on: stack fault resets
//
// The Avalon-MM register port was decided locally.
module pcrs_core #(
  parameter int PC_W = 15,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // core sequencing
  input wire logic op_valid,
  input wire pcrs_pkg::pcrs_op_type op,
  input wire logic [10:0] op_target,
  input wire logic [8:0] op_offset,
  input wire logic [7:0] acc_value,
  input wire logic pc_low_write,
  input wire logic [7:0] pc_low_wdata,
  input wire logic [14:0] vector_addr,
  input wire logic [8*pcrs_pkg::N_COPIES-1:0] context_in,
  input wire logic stack_fault_reset_enable,
  // core outputs
  output logic [14:0] pc,
  output logic stack_fault_reset,
  output logic [8*pcrs_pkg::N_COPIES-1:0] context_out,
  // avalon-mm slave
  input wire logic [13:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response
);
  logic [14:0] pc_reg;
  logic [6:0] latch_reg;
  logic [4:0] index_reg;
  logic ovf_reg;
  logic unf_reg;
  logic fault_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [1:0] resp_reg;
  logic [14:0] top_data;
  logic [14:0] pc_inc;
  logic [11:0] word_idx;
  logic do_push;
  logic do_pop;
  logic push_ovf;
  logic pop_unf;
  logic bus_req;
  logic bus_wr;
  logic sw_index_wr;
  logic sw_top_wr;
  logic [14:0] sw_top_data;
  logic [4:0] push_idx;
  logic copy_wr;

  function automatic logic is_copy(input logic [11:0] ix);
    is_copy = ix >= pcrs_pkg::IX_STATUS_COPY && ix <= pcrs_pkg::IX_PTR1H_COPY;
  endfunction

  assign word_idx = avs_address[13:2];
  assign bus_req = (avs_read || avs_write) && !ack_reg;
  assign bus_wr = avs_write && !ack_reg;
  // answer one cycle after request, waitrequest low on second edge
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign avs_readdata = rdata_reg;
  assign avs_response = resp_reg;
  assign pc = pc_reg;
  assign stack_fault_reset = fault_reg;
  assign pc_inc = pc_reg + 15'h0001;

  assign do_push = op_valid && (op == pcrs_pkg::PCRS_OP_CALL || op == pcrs_pkg::PCRS_OP_COMPUTED_SUBROUTINE_INSTR
                   || op == pcrs_pkg::PCRS_OP_VECTOR);
  assign do_pop = op_valid && op == pcrs_pkg::PCRS_OP_RETURN;
  // full means index at last entry; empty is the 0x1f code
  assign push_ovf = do_push && index_reg == pcrs_pkg::IDX_FULL;
  assign pop_unf = do_pop && index_reg == pcrs_pkg::IDX_EMPTY;
  assign push_idx = index_reg + 5'h01;

  assign sw_index_wr = bus_wr && word_idx == pcrs_pkg::IX_STACK_INDEX;
  assign sw_top_wr = bus_wr && (word_idx == pcrs_pkg::IX_TOP_LOW
                     || word_idx == pcrs_pkg::IX_TOP_HIGH);
  assign sw_top_data = (word_idx == pcrs_pkg::IX_TOP_LOW) ?
                       {top_data[14:8], avs_writedata[7:0]} :
                       {avs_writedata[6:0], top_data[7:0]};
  assign copy_wr = bus_wr && is_copy(word_idx);

  pcrs_stack_mem #(.DEPTH(DEPTH), .WIDTH(PC_W)) u_stack (
    .sys_clk(sys_clk),
    .wr_en(do_push || sw_top_wr),
    .wr_idx(do_push ? push_idx[3:0] : index_reg[3:0]),
    .wr_data(do_push ? pc_inc : sw_top_data),
    .rd_idx(index_reg[3:0]),
    .rd_data(top_data)
  );

  pcrs_context_copy #(.N(pcrs_pkg::N_COPIES)) u_copy (
    .sys_clk(sys_clk),
    .save(op_valid && op == pcrs_pkg::PCRS_OP_VECTOR),
    .save_data(context_in),
    .sw_wr(copy_wr),
    .sw_idx(3'(word_idx - pcrs_pkg::IX_STATUS_COPY)),
    .sw_data(avs_writedata[7:0]),
    .copy_data(context_out)
  );

  // program counter
  always_ff @(posedge sys_clk) begin
    if (reset || fault_reg) begin
      pc_reg <= pcrs_pkg::PC_RESET;
    end else if (pc_low_write) begin
      pc_reg <= {latch_reg, pc_low_wdata};
    end else if (op_valid) begin
      case (op)
        pcrs_pkg::PCRS_OP_STEP: pc_reg <= pc_inc;
        pcrs_pkg::PCRS_OP_CALL: pc_reg <= {latch_reg[6:3], op_target};
        pcrs_pkg::PCRS_OP_COMPUTED_SUBROUTINE_INSTR: pc_reg <= {latch_reg, acc_value};
        pcrs_pkg::PCRS_OP_JUMPW: pc_reg <= pc_inc + {7'h00, acc_value};
        pcrs_pkg::PCRS_OP_JUMPREL: begin
          pc_reg <= pc_inc + {{6{op_offset[8]}}, op_offset};
        end
        pcrs_pkg::PCRS_OP_RETURN: pc_reg <= top_data;
        pcrs_pkg::PCRS_OP_VECTOR: pc_reg <= vector_addr;
        default: pc_reg <= pc_reg;
      endcase
    end
  end

  // high holding latch, software only; stack ops leave it alone
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      latch_reg <= 7'h00;
    end else if (bus_wr && word_idx == pcrs_pkg::IX_PC_LATCH) begin
      latch_reg <= avs_writedata[6:0];
    end
  end

  // stack index
  always_ff @(posedge sys_clk) begin
    if (reset || fault_reg) begin
      index_reg <= pcrs_pkg::IDX_EMPTY;
    end else if (do_push) begin
      index_reg <= {1'b0, push_idx[3:0]};
    end else if (do_pop) begin
      index_reg <= index_reg - 5'h01;
    end else if (sw_index_wr) begin
      index_reg <= avs_writedata[4:0];
    end
  end

  // sticky flags, set beats software clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ovf_reg <= 1'b0;
      unf_reg <= 1'b0;
    end else begin
      if (push_ovf) begin
        ovf_reg <= 1'b1;
      end else if (bus_wr && word_idx == pcrs_pkg::IX_FLAGS
                   && !avs_writedata[pcrs_pkg::FLAG_OVF]) begin
        ovf_reg <= 1'b0;
      end
      if (pop_unf) begin
        unf_reg <= 1'b1;
      end else if (bus_wr && word_idx == pcrs_pkg::IX_FLAGS
                   && !avs_writedata[pcrs_pkg::FLAG_UNF]) begin
        unf_reg <= 1'b0;
      end
    end
  end

  // fault reset pulse; flags kept so software sees the cause
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= stack_fault_reset_enable && (push_ovf || pop_unf);
    end
  end

  // bus answer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      resp_reg <= 2'h0;
    end else begin
      ack_reg <= bus_req;
      if (bus_req) begin
        resp_reg <= 2'h0;
        rdata_reg <= 32'h0000_0000;
        if (is_copy(word_idx)) begin
          rdata_reg <= {24'h000000,
                        context_out[8*(word_idx - pcrs_pkg::IX_STATUS_COPY) +: 8]};
        end else begin
          case (word_idx)
            pcrs_pkg::IX_PC_LOW: rdata_reg <= {24'h000000, pc_reg[7:0]};
            pcrs_pkg::IX_PC_LATCH: rdata_reg <= {25'h0000000, latch_reg};
            pcrs_pkg::IX_STACK_INDEX: rdata_reg <= {27'h0000000, index_reg};
            pcrs_pkg::IX_TOP_LOW: rdata_reg <= {24'h000000, top_data[7:0]};
            pcrs_pkg::IX_TOP_HIGH: rdata_reg <= {25'h0000000, top_data[14:8]};
            pcrs_pkg::IX_FLAGS: begin
              rdata_reg <= {29'h00000000, stack_fault_reset_enable, unf_reg, ovf_reg};
            end
            default: resp_reg <= 2'h2;
          endcase
        end
      end
    end
  end

  // checks
  sequence push_seen;
    do_push && !fault_reg && !reset;
  endsequence

  // a low byte write or a pending fault reset overrides the decoded op
  sequence op_seen(pcrs_pkg::pcrs_op_type kind);
    op_valid && op == kind && !pc_low_write && !fault_reg;
  endsequence

  // stack fault with the option on: pulse first, clearing one edge later
  sequence stack_fault;
    ((push_ovf || pop_unf) && stack_fault_reset_enable) ##1 fault_reg;
  endsequence

  stack_empty_a: assert property (@(posedge sys_clk)
    $past(reset) |-> index_reg == 5'h1f)
    else $error("index not empty after reset");
  pc_reset_a: assert property (@(posedge sys_clk)
    $past(reset) |-> pc_reg == 15'h0000)
    else $error("pc not cleared by reset");
  push_index_a: assert property (@(posedge sys_clk) disable iff (reset)
    push_seen |=> index_reg == {1'b0, 4'($past(index_reg) + 5'h01)})
    else $error("push did not advance index");
  ovf_flag_a: assert property (@(posedge sys_clk) disable iff (reset)
    push_ovf |=> ovf_reg)
    else $error("overflow flag missing");
  unf_flag_a: assert property (@(posedge sys_clk) disable iff (reset)
    pop_unf |=> unf_reg)
    else $error("underflow flag missing");
  fault_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
    stack_fault |=> index_reg == 5'h1f && pc_reg == 15'h0000)
    else $error("stack fault did not reset");
  latch_jump_a: assert property (@(posedge sys_clk) disable iff (reset || fault_reg)
    pc_low_write |=> pc_reg[14:8] == $past(latch_reg))
    else $error("upper pc not from latch");
  rel_jump_a: assert property (@(posedge sys_clk) disable iff (reset || fault_reg)
    (op_valid && op == pcrs_pkg::PCRS_OP_JUMPREL && !pc_low_write) |=>
    pc_reg == 15'($past(pc_reg) + 15'h0001 + {{6{$past(op_offset[8])}}, $past(op_offset)}))
    else $error("relative jump target wrong");
  wrap_a: assert property (@(posedge sys_clk) disable iff (reset)
    (push_seen and (index_reg == 5'h0f && !stack_fault_reset_enable)) |=> index_reg == 5'h00)
    else $error("stack did not wrap");
  call_latch_a: assert property (@(posedge sys_clk) disable iff (reset)
    (do_push || do_pop) && !bus_wr |=> $stable(latch_reg))
    else $error("stack op changed latch");
  bus_answer_a: assert property (@(posedge sys_clk) disable iff (reset)
    bus_req |=> !avs_waitrequest)
    else $error("bus answer late");

  // each op's target, from the values held when it was taken
  call_target_a: assert property (@(posedge sys_clk) disable iff (reset)
    op_seen(pcrs_pkg::PCRS_OP_CALL) |=> pc_reg == {$past(latch_reg[6:3]), $past(op_target)})
    else $error("call target wrong");
  computed_subroutine_instr_target_a: assert property (@(posedge sys_clk) disable iff (reset)
    op_seen(pcrs_pkg::PCRS_OP_COMPUTED_SUBROUTINE_INSTR) |=> pc_reg == {$past(latch_reg), $past(acc_value)})
    else $error("computed call target wrong");
  jumpw_target_a: assert property (@(posedge sys_clk) disable iff (reset)
    op_seen(pcrs_pkg::PCRS_OP_JUMPW) |=>
    pc_reg == 15'($past(pc_reg) + 15'h0001 + {7'h00, $past(acc_value)}))
    else $error("register jump target wrong");
  step_pc_a: assert property (@(posedge sys_clk) disable iff (reset)
    op_seen(pcrs_pkg::PCRS_OP_STEP) |=> pc_reg == 15'($past(pc_reg) + 15'h0001))
    else $error("step did not increment");
  vector_pc_a: assert property (@(posedge sys_clk) disable iff (reset)
    op_seen(pcrs_pkg::PCRS_OP_VECTOR) |=> pc_reg == $past(vector_addr))
    else $error("vector target wrong");
  return_pc_a: assert property (@(posedge sys_clk) disable iff (reset)
    op_seen(pcrs_pkg::PCRS_OP_RETURN) |=> pc_reg == $past(top_data))
    else $error("return address wrong");
  low_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    (pc_low_write && !fault_reg) |=> pc_reg[7:0] == $past(pc_low_wdata))
    else $error("low byte write lost");

  // stack index and entries
  pop_index_a: assert property (@(posedge sys_clk) disable iff (reset)
    (do_pop && !fault_reg) |=> index_reg == 5'($past(index_reg) - 5'h01))
    else $error("pop did not step index back");
  push_store_a: assert property (@(posedge sys_clk) disable iff (reset)
    push_seen |=> top_data == 15'($past(pc_reg) + 15'h0001))
    else $error("pushed entry wrong");
  index_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    (sw_index_wr && !do_push && !do_pop && !fault_reg) |=> index_reg == $past(avs_writedata[4:0]))
    else $error("index write lost");

  // register slave and software side state
  index_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    (bus_req && !avs_write && word_idx == pcrs_pkg::IX_STACK_INDEX) |=>
    avs_readdata == {27'h0000000, $past(index_reg)})
    else $error("index read wrong");
  latch_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    (bus_wr && word_idx == pcrs_pkg::IX_PC_LATCH) |=> latch_reg == $past(avs_writedata[6:0]))
    else $error("latch write lost");
  ovf_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    (bus_wr && word_idx == pcrs_pkg::IX_FLAGS && !avs_writedata[pcrs_pkg::FLAG_OVF]
     && !push_ovf) |=> !ovf_reg)
    else $error("overflow flag not cleared");
  unf_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
    (bus_wr && word_idx == pcrs_pkg::IX_FLAGS && !avs_writedata[pcrs_pkg::FLAG_UNF]
     && !pop_unf) |=> !unf_reg)
    else $error("underflow flag not cleared");
  unmapped_resp_a: assert property (@(posedge sys_clk) disable iff (reset)
    (bus_req && word_idx == 12'hfec) |=> avs_response == 2'h2)
    else $error("unmapped access not refused");
  idle_wait_a: assert property (@(posedge sys_clk) disable iff (reset)
    !(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  context_save_a: assert property (@(posedge sys_clk) disable iff (reset)
    (op_valid && op == pcrs_pkg::PCRS_OP_VECTOR) |=> context_out == $past(context_in))
    else $error("context not saved on vector");
endmodule

// [test/tb.sv]
// self-checking bench for the program counter and return stack
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic op_valid = 1'h0;
  pcrs_pkg::pcrs_op_type op = pcrs_pkg::PCRS_OP_NONE;
  logic [10:0] op_target = '0;
  logic [8:0] op_offset = '0;
  logic [7:0] acc_value = '0;
  logic pc_low_write = 1'h0;
  logic [7:0] pc_low_wdata = '0;
  logic [14:0] vector_addr = '0;
  logic [63:0] context_in = '0;
  logic stack_fault_reset_enable = 1'h0;
  logic [14:0] pc;
  logic stack_fault_reset;
  logic [63:0] context_out;
  logic [13:0] avs_address = '0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic [1:0] resp;
  logic [31:0] q;
  logic [14:0] pm;
  logic [6:0] lm;
  logic [10:0] x;
  logic [14:0] stk [16];
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;

  pcrs_core pcrs_core_inst (.sys_clk, .reset, .op_valid, .op, .op_target, .op_offset,
    .acc_value, .pc_low_write, .pc_low_wdata, .vector_addr, .context_in,
    .stack_fault_reset_enable, .pc, .stack_fault_reset, .context_out, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .avs_response);

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic summarize;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      summarize;
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // holds the request until waitrequest is sampled low; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [11:0] ix, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= {ix, 2'h0};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    resp = avs_response;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask

  task automatic rd(input logic [11:0] ix, input logic [31:0] e);
    bus(1'h0, ix, '0);
    check(q, e);
  endtask

  task automatic run(input pcrs_pkg::pcrs_op_type o, input logic lw, input logic [10:0] v);
    @(posedge sys_clk);
    op_valid <= !lw;
    pc_low_write <= lw;
    op <= o;
    op_target <= v;
    op_offset <= v[8:0];
    acc_value <= v[7:0];
    pc_low_wdata <= v[7:0];
    vector_addr <= 15'($urandom);
    context_in <= {$urandom, $urandom};
    @(posedge sys_clk);
    op_valid <= 1'h0;
    pc_low_write <= 1'h0;
    #1;
  endtask

  function automatic logic [14:0] nxt(input pcrs_pkg::pcrs_op_type o, input logic [10:0] v);
    case (o)
      pcrs_pkg::PCRS_OP_CALL: return {lm[6:3], v};
      pcrs_pkg::PCRS_OP_COMPUTED_SUBROUTINE_INSTR: return {lm, v[7:0]};
      pcrs_pkg::PCRS_OP_JUMPW: return pm + 15'h1 + {7'h0, v[7:0]};
      pcrs_pkg::PCRS_OP_STEP: return pm + 15'h1;
      default: return pm + 15'h1 + {{6{v[8]}}, v[8:0]};
    endcase
  endfunction

  task automatic go(input pcrs_pkg::pcrs_op_type o, input logic [10:0] v);
    logic [14:0] e;
    e = nxt(o, v);
    run(o, 1'h0, v);
    check(pc, e);
    pm = e;
  endtask

  initial begin
    void'($urandom(30));
    repeat (2) @(posedge sys_clk);
    reset <= 1'h0;
    #1;
    check(pc, '0);
    rd(pcrs_pkg::IX_STACK_INDEX, 32'h1f);
    lm = 7'($urandom);
    bus(1'h1, pcrs_pkg::IX_PC_LATCH, {25'h0, lm});
    x = 11'($urandom);
    run(pcrs_pkg::PCRS_OP_NONE, 1'h1, x);
    pm = {lm, x[7:0]};
    check(pc, pm);
    rd(pcrs_pkg::IX_PC_LOW, pm[7:0]);
    for (int i = 0; i < 16; i++) begin
      stk[i] = pm + 15'h1;
      go(pcrs_pkg::PCRS_OP_CALL, 11'($urandom));
      if (i == 0) rd(pcrs_pkg::IX_STACK_INDEX, 32'h0);
    end
    rd(pcrs_pkg::IX_STACK_INDEX, 32'hf);
    rd(pcrs_pkg::IX_TOP_HIGH, stk[15][14:8]);
    rd(pcrs_pkg::IX_FLAGS, 32'h0);
    stk[0] = pm + 15'h1;
    go(pcrs_pkg::PCRS_OP_COMPUTED_SUBROUTINE_INSTR, 11'($urandom));
    rd(pcrs_pkg::IX_FLAGS, 32'h1);
    rd(pcrs_pkg::IX_STACK_INDEX, 32'h0);
    rd(pcrs_pkg::IX_TOP_LOW, stk[0][7:0]);
    // rewrite the low byte of entry seven through the top low register, then unwind from it
    bus(1'h1, pcrs_pkg::IX_STACK_INDEX, 32'h7);
    rd(pcrs_pkg::IX_TOP_HIGH, stk[7][14:8]);
    x = 11'($urandom);
    bus(1'h1, pcrs_pkg::IX_TOP_LOW, x[7:0]);
    stk[7][7:0] = x[7:0];
    for (int i = 7; i >= 0; i--) begin
      run(pcrs_pkg::PCRS_OP_RETURN, 1'h0, '0);
      check(pc, stk[i]);
    end
    rd(pcrs_pkg::IX_STACK_INDEX, 32'h1f);
    run(pcrs_pkg::PCRS_OP_RETURN, 1'h0, '0);
    rd(pcrs_pkg::IX_FLAGS, 32'h3);
    rd(pcrs_pkg::IX_STACK_INDEX, 32'h1e);
    rd(pcrs_pkg::IX_PC_LATCH, lm);
    bus(1'h1, pcrs_pkg::IX_FLAGS, '0);
    rd(pcrs_pkg::IX_FLAGS, 32'h0);
    x = 11'($urandom);
    run(pcrs_pkg::PCRS_OP_NONE, 1'h1, x);
    pm = {lm, x[7:0]};
    check(pc, pm);
    for (int i = 0; i < 8; i++) begin
      x = (i < 2) ? 11'h0ff : (i < 4) ? 11'h100 : 11'($urandom);
      go(i[0] ? pcrs_pkg::PCRS_OP_JUMPW : pcrs_pkg::PCRS_OP_JUMPREL, x);
    end
    go(pcrs_pkg::PCRS_OP_STEP, 11'h000);
    for (int i = 0; i < 8; i++) begin
      x = 11'($urandom);
      bus(1'h1, pcrs_pkg::IX_STATUS_COPY + 12'(i), {24'h0, x[7:0]});
      rd(pcrs_pkg::IX_STATUS_COPY + 12'(i), {24'h0, x[7:0]});
    end
    q = context_out[31:0];
    @(posedge sys_clk);
    reset <= 1'h1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'h0;
    #1;
    check(pc, '0);
    check(context_out[31:0], q);
    run(pcrs_pkg::PCRS_OP_VECTOR, 1'h0, '0);
    check(pc, vector_addr);
    check(context_out, context_in);
    rd(pcrs_pkg::IX_TOP_LOW, 32'h1);
    bus(1'h0, 12'hfec, '0);
    check(q, '0);
    check(resp, 2'h2);
    run(pcrs_pkg::PCRS_OP_RETURN, 1'h0, '0);
    check(pc, 15'h1);
    @(posedge sys_clk);
    stack_fault_reset_enable <= 1'h1;
    run(pcrs_pkg::PCRS_OP_RETURN, 1'h0, '0);
    check(stack_fault_reset, 1'h1);
    @(posedge sys_clk);
    #1;
    check(pc, '0);
    rd(pcrs_pkg::IX_FLAGS, 32'h6);
    summarize;
  end
endmodule
